// >>> core/stls_cfg_if.sv
`timescale 1ns/10ps
// limit enables and values handed from the top to the comparator
interface stls_cfg_if;
   logic                            fwd_en;
   logic                            rev_en;
   logic signed [stls_pkg::POS_W-1:0] fwd_lim;
   logic signed [stls_pkg::POS_W-1:0] rev_lim;

   modport src (output fwd_en, output rev_en, output fwd_lim, output rev_lim);
   modport dst (input fwd_en, input rev_en, input fwd_lim, input rev_lim);
endinterface : stls_cfg_if

// >>> core/stls_compare.sv
`timescale 1ns/10ps
// per-direction limit comparison, combinational
module stls_compare (
   stls_cfg_if.dst                       cfg,
   input  wire logic signed [31:0]       pos,
   input  wire logic                     mov_fwd,
   input  wire logic                     mov_rev,
   output logic                          over_fwd,
   output logic                          over_rev
);
   // direction gates the check so an axis backing out of a limit is not held
   always_comb begin
      over_fwd = cfg.fwd_en && mov_fwd && (pos > cfg.fwd_lim); // [RULE_15]
      over_rev = cfg.rev_en && mov_rev && (pos < cfg.rev_lim); // [RULE_15]
   end
endmodule : stls_compare

// >>> core/stls_pkg.sv
package stls_pkg;

   // position word width: limits span +/- 1073741823, so 32 bits signed
   localparam int POS_W = 32;

   // soft limit select field encodings
   localparam logic [1:0] SEL_BOTH_ON   = 2'h0;
   localparam logic [1:0] SEL_FWD_OFF   = 2'h1;
   localparam logic [1:0] SEL_REV_OFF   = 2'h2;
   localparam logic [1:0] SEL_BOTH_OFF  = 2'h3;

   // factory defaults, kept as reference values only; no port or reset uses them
   localparam logic [1:0]        SEL_DEFAULT     = SEL_BOTH_OFF;
   localparam logic              CMD_CHK_DEFAULT = 1'h0;
   localparam logic signed [31:0] FWD_LIMIT_DEFAULT = 32'sh3fffffff;
   localparam logic signed [31:0] REV_LIMIT_DEFAULT = -32'sh3fffffff;

   // supervisor states, gray along idle -> armed -> stopped
   typedef enum logic [1:0] {
      STLS_IDLE    = 2'b00,
      STLS_ARMED   = 2'b01,
      STLS_STOPPED = 2'b11
   } stls_state_t;

endpackage : stls_pkg

// >>> core/stls_supervisor.sv
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - select 0 enforces both soft limits
// RULE_02 - select 1 drops only forward limit
// RULE_03 - select 2 drops only reverse limit
// RULE_04 - select 3 drops both, immediate effect
// RULE_05 - home return completion arms checking
// RULE_06 - coordinate set with flag arms checking
// RULE_07 - absolute encoder sensor on arms checking
// RULE_08 - no action before origin established
// RULE_09 - armed and enabled: stop past limit
// RULE_10 - forward limit signed, immediate effect
// RULE_11 - reverse limit signed, immediate effect
// RULE_12 - host keeps reverse below forward
// RULE_13 - command check field enables target checking
// RULE_14 - target beyond limit: rest at limit
// RULE_15 - directional signed position comparison
module stls_supervisor (
   input  wire logic               clk_sys,
   input  wire logic               arst_n,
   input  wire logic [1:0]         soft_limit_select_param,
   input  wire logic               cmd_check_enable,
   input  wire logic signed [31:0] forward_soft_limit_value,
   input  wire logic signed [31:0] reverse_soft_limit_value,
   input  wire logic               abs_encoder_fitted,
   input  wire logic               home_return_done,
   input  wire logic               coord_set_exec,
   input  wire logic               reference_established_flag,
   input  wire logic               encoder_sensor_on_done,
   input  wire logic signed [31:0] axis_position,
   input  wire logic               moving_fwd,
   input  wire logic               moving_rev,
   input  wire logic               target_valid,
   input  wire logic signed [31:0] target_position,
   output logic                    armed,
   output logic                    force_stop,
   output logic                    fwd_limit_hit,
   output logic                    rev_limit_hit,
   output logic signed [31:0]      target_clamped,
   output logic                    target_clamped_valid,
   output logic                    target_decel
);

   ////////////////////////////////////////////////////////////////////////////
   // direction enables decoded straight from the select field
   stls_cfg_if cfg ();
   logic over_fwd;
   logic over_rev;

   // no register on the field, so a change acts on the next compare
   assign cfg.fwd_en  = (soft_limit_select_param == stls_pkg::SEL_BOTH_ON) || // [RULE_01]
                        (soft_limit_select_param == stls_pkg::SEL_REV_OFF);   // [RULE_03]
   assign cfg.rev_en  = (soft_limit_select_param == stls_pkg::SEL_BOTH_ON) || // [RULE_01]
                        (soft_limit_select_param == stls_pkg::SEL_FWD_OFF);   // [RULE_02] [RULE_04]
   assign cfg.fwd_lim = forward_soft_limit_value; // [RULE_10]
   assign cfg.rev_lim = reverse_soft_limit_value; // [RULE_11]

   stls_compare u_cmp (
      .cfg      (cfg),
      .pos      (axis_position),
      .mov_fwd  (moving_fwd),
      .mov_rev  (moving_rev),
      .over_fwd (over_fwd),
      .over_rev (over_rev)
   );

   ////////////////////////////////////////////////////////////////////////////
   // arming: any origin-establishing event, held until reset
   stls_pkg::stls_state_t state_reg;
   stls_pkg::stls_state_t state_next;
   logic                  origin_evt;

   assign origin_evt = home_return_done                                    // [RULE_05]
                     || (coord_set_exec && reference_established_flag)   // [RULE_06]
                     || (abs_encoder_fitted && encoder_sensor_on_done);  // [RULE_07]

   // stopped is released once the axis no longer moves past a limit
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         stls_pkg::STLS_IDLE: begin
            if (origin_evt) state_next = stls_pkg::STLS_ARMED;
         end
         stls_pkg::STLS_ARMED: begin
            if (over_fwd || over_rev) state_next = stls_pkg::STLS_STOPPED; // [RULE_09]
         end
         stls_pkg::STLS_STOPPED: begin
            if (!(over_fwd || over_rev)) state_next = stls_pkg::STLS_ARMED;
         end
         default: state_next = stls_pkg::STLS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) state_reg <= stls_pkg::STLS_IDLE;
      else         state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // stop outputs, registered; idle suppresses force_stop and both limit hit flags
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         armed         <= 1'b0;
         force_stop    <= 1'b0;
         fwd_limit_hit <= 1'b0;
         rev_limit_hit <= 1'b0;
      end else begin
         armed         <= (state_next != stls_pkg::STLS_IDLE);
         force_stop    <= (state_reg != stls_pkg::STLS_IDLE) && (over_fwd || over_rev); // [RULE_08] [RULE_09]
         fwd_limit_hit <= (state_reg != stls_pkg::STLS_IDLE) && over_fwd;
         rev_limit_hit <= (state_reg != stls_pkg::STLS_IDLE) && over_rev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command target check: clamp target to the enabled limit so the profile
   // decelerates to rest exactly on it; the host keeps rev < fwd, so the two
   // clamps never conflict
   logic target_hi;
   logic target_lo;
   logic chk_on;

   assign chk_on    = cmd_check_enable && (state_reg != stls_pkg::STLS_IDLE); // [RULE_13] [RULE_12]
   assign target_hi = chk_on && cfg.fwd_en && (target_position > forward_soft_limit_value);
   assign target_lo = chk_on && cfg.rev_en && (target_position < reverse_soft_limit_value);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         target_clamped       <= 32'sh0;
         target_clamped_valid <= 1'b0;
         target_decel         <= 1'b0;
      end else begin
         target_clamped_valid <= target_valid;
         if (target_valid) begin
            if (target_hi)      target_clamped <= forward_soft_limit_value; // [RULE_14]
            else if (target_lo) target_clamped <= reverse_soft_limit_value; // [RULE_14]
            else                target_clamped <= target_position;
            target_decel <= target_hi || target_lo;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_idle_no_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state_reg == stls_pkg::STLS_IDLE) |=> !force_stop)
      else $error("stop raised before origin established"); // [RULE_08]
   a_home_arms: assert property (@(posedge clk_sys) disable iff (!arst_n)
      home_return_done |=> armed)
      else $error("home return did not arm"); // [RULE_05]
   a_coord_arms: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (coord_set_exec && reference_established_flag) |=> armed)
      else $error("coordinate set did not arm"); // [RULE_06]
   a_sensor_arms: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (abs_encoder_fitted && encoder_sensor_on_done) |=> armed)
      else $error("sensor on did not arm"); // [RULE_07]
   a_fwd_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (armed && moving_fwd && axis_position > forward_soft_limit_value
       && soft_limit_select_param == stls_pkg::SEL_BOTH_ON) |=> force_stop)
      else $error("forward overrun not stopped"); // [RULE_01]
   a_fwd_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (soft_limit_select_param == stls_pkg::SEL_FWD_OFF) |=> !fwd_limit_hit)
      else $error("forward limit acted while disabled"); // [RULE_02]
   a_rev_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (soft_limit_select_param == stls_pkg::SEL_REV_OFF) |=> !rev_limit_hit)
      else $error("reverse limit acted while disabled"); // [RULE_03]
   a_both_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (soft_limit_select_param == stls_pkg::SEL_BOTH_OFF) |=> !force_stop)
      else $error("stop while both limits disabled"); // [RULE_04]
   a_clamp_hi: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (target_valid && target_hi) |=> (target_clamped == $past(forward_soft_limit_value)))
      else $error("target not clamped to forward limit"); // [RULE_14]

   // the remaining checks cover the other select values, the reverse side,
   // the direction gate and the command check; each is reachable by the
   // bench traffic, which straddles both limits in every select value
   a_rev_stop: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE_01]
      (armed && moving_rev && axis_position < reverse_soft_limit_value
       && soft_limit_select_param == stls_pkg::SEL_BOTH_ON) |=> force_stop)
      else $error("reverse overrun not stopped");
   a_sel2_fwd_on: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE_03]
      (armed && moving_fwd && axis_position > forward_soft_limit_value
       && soft_limit_select_param == stls_pkg::SEL_REV_OFF) |=> fwd_limit_hit)
      else $error("forward limit not kept with reverse disabled");
   a_sel1_rev_on: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE_02]
      (armed && moving_rev && axis_position < reverse_soft_limit_value
       && soft_limit_select_param == stls_pkg::SEL_FWD_OFF) |=> rev_limit_hit)
      else $error("reverse limit not kept with forward disabled");
   // arming is permanent until reset: no event may take it away
   a_arm_holds: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE_05]
      armed |=> armed)
      else $error("armed dropped without reset");
   // an axis not moving forward must never be flagged on the forward side
   a_dir_gate: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE_15]
      (!moving_fwd) |=> !fwd_limit_hit)
      else $error("forward hit flagged while not moving forward");
   a_clamp_lo: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE_14]
      (target_valid && target_lo && !target_hi)
      |=> (target_clamped == $past(reverse_soft_limit_value)))
      else $error("target not clamped to reverse limit");
   a_chk_off: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE_13]
      (target_valid && !cmd_check_enable) |=> !target_decel)
      else $error("target clamped with command check off");

endmodule : stls_supervisor

// >>> tb/stls_host_model.sv
`timescale 1ns/10ps
// host side: opcode to command pulses, limits always kept ordered
module stls_host_model (
   input  wire logic [2:0]         op,
   input  wire logic [15:0]        raw_a,
   input  wire logic [15:0]        raw_b,
   output logic                    home_return_done,
   output logic                    coord_set_exec,
   output logic                    reference_established_flag,
   output logic                    encoder_sensor_on_done,
   output logic signed [31:0]      forward_soft_limit_value,
   output logic signed [31:0]      reverse_soft_limit_value
);
   logic signed [31:0] a, b;
   ////////////////////////////////////////
   // equal raw values are pulled apart so reverse never meets forward
   assign a = $signed(raw_a);
   assign b = $signed(raw_b);
   assign reverse_soft_limit_value = (a < b) ? a : b;
   assign forward_soft_limit_value = (a < b) ? b : a + 32'sh1;
   // one opcode per cycle, so commands never overlap
   assign home_return_done           = op == 3'h1;
   assign coord_set_exec             = op == 3'h2 || op == 3'h3;
   assign reference_established_flag = op == 3'h2;
   assign encoder_sensor_on_done     = op == 3'h4;
endmodule : stls_host_model

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
   logic               clk_sys = 0, arst_n = 0, abs_encoder_fitted = 0, cmd_check_enable = 0;
   logic               moving_fwd = 0, moving_rev = 0, target_valid = 0, armed, force_stop;
   logic               home_return_done, coord_set_exec, reference_established_flag;
   logic               encoder_sensor_on_done, fwd_limit_hit, rev_limit_hit, target_decel;
   logic               target_clamped_valid, arm_m, e_f, e_r, e_d, e_v;
   logic        [1:0]  soft_limit_select_param = 0;
   logic        [2:0]  op = 0;
   logic        [31:0] rnd = 32'h3c82, lim_raw = 0;
   logic signed [31:0] axis_position = 0, target_position = 0, target_clamped, e_c;
   logic signed [31:0] forward_soft_limit_value, reverse_soft_limit_value;
   int                 n_fail = 0, n_compared = 0, cyc = 0;
   ////////////////////////////////////////
   stls_supervisor dut (.clk_sys, .arst_n, .soft_limit_select_param, .cmd_check_enable,
      .forward_soft_limit_value, .reverse_soft_limit_value, .abs_encoder_fitted,
      .home_return_done, .coord_set_exec, .reference_established_flag,
      .encoder_sensor_on_done, .axis_position, .moving_fwd, .moving_rev, .target_valid,
      .target_position, .armed, .force_stop, .fwd_limit_hit, .rev_limit_hit,
      .target_clamped, .target_clamped_valid, .target_decel);
   stls_host_model host (.op, .raw_a(lim_raw[15:0]), .raw_b(lim_raw[31:16]),
      .home_return_done, .coord_set_exec, .reference_established_flag,
      .encoder_sensor_on_done, .forward_soft_limit_value, .reverse_soft_limit_value);
   ////////////////////////////////////////
   // 20 MHz clock and a cycle ceiling against hangs
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         print_verdict;
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // reset held 12 cycles; model state cleared with it
   task rst;
      arst_n = 0;
      op = 0;
      {arm_m, e_f, e_r, e_d, e_v, e_c} = 0;
      repeat (12) @(negedge clk_sys);
      arst_n = 1;
   endtask : rst
   // model predicts from inputs before the edge, compares after it
   task step;
      logic               fe, re;
      logic signed [31:0] f, r;
      f = forward_soft_limit_value;
      r = reverse_soft_limit_value;
      fe = soft_limit_select_param inside {2'h0, 2'h2};
      re = soft_limit_select_param inside {2'h0, 2'h1};
      e_f = arm_m && fe && moving_fwd && axis_position > f;
      e_r = arm_m && re && moving_rev && axis_position < r;
      e_v = target_valid;
      if (target_valid) begin
         e_c = target_position;
         e_d = arm_m && cmd_check_enable && (fe && e_c > f || re && e_c < r);
         if (e_d)
            e_c = (fe && e_c > f) ? f : r;
      end
      if (home_return_done || encoder_sensor_on_done && abs_encoder_fitted
          || coord_set_exec && reference_established_flag)
         arm_m = 1;
      @(negedge clk_sys);
      chk("armed", arm_m, armed);
      chk("fwd_hit", e_f, fwd_limit_hit);
      chk("rev_hit", e_r, rev_limit_hit);
      chk("stop", e_f | e_r, force_stop);
      chk("tgt_valid", e_v, target_clamped_valid);
      chk("tgt", e_c, target_clamped);
      chk("decel", e_d, target_decel);
   endtask : step
   // random traffic straddling the limits; pre mode sends only non-arming commands
   task run(input int n, input bit pre);
      repeat (n) begin
         rnd = lfsr(rnd);
         soft_limit_select_param = rnd[1:0];
         cmd_check_enable = rnd[2];
         moving_fwd = rnd[3];
         moving_rev = rnd[4] & ~rnd[3];
         target_valid = rnd[5];
         op = pre ? (rnd[7] ? 3'h3 : 3'h4) : 3'h0;
         if (rnd[19:17] == 3'h0) begin
            lim_raw = lfsr(~rnd);
            #1;
         end
         axis_position = (rnd[6] ? forward_soft_limit_value : reverse_soft_limit_value)
                         + 32'(rnd[11:8]) - 32'sh8;
         target_position = (rnd[16] ? forward_soft_limit_value : reverse_soft_limit_value)
                           + 32'(rnd[15:12]) - 32'sh8;
         step;
      end
   endtask : run
   ////////////////////////////////////////
   // each pass: unarmed traffic, one arming command, then armed traffic
   initial begin
      for (int k = 0; k < 3; k++) begin
         rst;
         abs_encoder_fitted = 0;
         run(20, 1);
         abs_encoder_fitted = 1;
         op = k == 0 ? 3'h1 : k == 1 ? 3'h2 : 3'h4;
         step;
         run(150, 0);
         $display("test %0d done, mismatches so far %0d", k, n_fail);
      end
      print_verdict;
   end
endmodule : tb
